// *** src/bus_region_access_protection.sv ***
`timescale 1ns/1ns
// Function
// RL1: Sixteen separately programmed region descriptors.
// RL2: Per region, independent rights per master.
// RL3: Sufficient rights let access reach slave.
// RL4: Unmapped or unprivileged access gets error.
// RL5: All descriptors checked in parallel matrix.
// RL6: Concurrent any-master to any-slave routing.
// RL7: Peripheral lock bit blocks protected writes.
// RL8: Pin config lock bit write-protects register.
// RL9: Inclusive bounds; any valid match grants.
module bus_region_access_protection (
	input  wire logic                                             clk_sys,
	input  wire logic                                             rst_n,
	input  wire logic                                             desc_wr_en,
	input  wire logic [3:0]                                       desc_wr_idx,
	input  wire bus_protect_pkg::region_desc_t                    desc_wr_data,
	input  wire logic [bus_protect_pkg::NUM_MASTERS-1:0]          m_req,
	input  wire logic [bus_protect_pkg::NUM_MASTERS-1:0][31:0]    m_addr,
	input  wire bus_protect_pkg::acc_kind_t [bus_protect_pkg::NUM_MASTERS-1:0] m_kind,
	input  wire logic [bus_protect_pkg::NUM_MASTERS-1:0][31:0]    m_wdata,
	output logic [bus_protect_pkg::NUM_MASTERS-1:0]               m_gnt,
	output logic [bus_protect_pkg::NUM_MASTERS-1:0]               m_done,
	output logic [bus_protect_pkg::NUM_MASTERS-1:0]               m_err,
	output logic [bus_protect_pkg::NUM_SLAVES-1:0]                s_req,
	output logic [bus_protect_pkg::NUM_SLAVES-1:0][31:0]          s_addr,
	output logic [bus_protect_pkg::NUM_SLAVES-1:0]                s_write,
	output logic [bus_protect_pkg::NUM_SLAVES-1:0][31:0]          s_wdata,
	input  wire logic [bus_protect_pkg::NUM_SLAVES-1:0]           s_ack,
	input  wire logic                                             periph_lock_set,
	input  wire logic                                             periph_prot_wr,
	output logic                                                  periph_wr_en,
	output logic                                                  periph_locked,
	input  wire logic                                             pin_config_lock_wr,
	input  wire logic                                             pin_config_wr,
	input  wire logic [31:0]                                      pin_config_wdata,
	output logic [31:0]                                           pin_config_q,
	output logic                                                  pin_config_write_lock
);
	localparam int unsigned NM = bus_protect_pkg::NUM_MASTERS;
	localparam int unsigned NS = bus_protect_pkg::NUM_SLAVES;
	localparam int unsigned NR = bus_protect_pkg::NUM_REGIONS;

	region_if rif ();

	assign rif.wr_en   = desc_wr_en;
	assign rif.wr_idx  = desc_wr_idx;
	assign rif.wr_desc = desc_wr_data;

	region_table i_region_table ( // see RL1
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.rif     (rif)
	);

	logic [NM-1:0][NR-1:0] hit;
	logic [NM-1:0]         allow;
	logic [NM-1:0]         tgt;

	// Match matrix: every master address against every descriptor at once
	for (genvar m = 0; m < NM; m++) begin : g_chk
		for (genvar r = 0; r < NR; r++) begin : g_reg
			logic [bus_protect_pkg::RIGHT_W-1:0] rt;
			logic                                inb;
			logic                                ok;
			assign rt  = rif.table_q[r].rights[m]; // see RL2
			assign inb = (m_addr[m] >= rif.table_q[r].start_addr) &&
				(m_addr[m] <= rif.table_q[r].end_addr); // see RL9
			always_comb begin
				unique case (m_kind[m])
					bus_protect_pkg::ACC_READ:  ok = rt[bus_protect_pkg::RIGHT_RD];
					bus_protect_pkg::ACC_WRITE: ok = rt[bus_protect_pkg::RIGHT_WR];
					bus_protect_pkg::ACC_FETCH: ok = rt[bus_protect_pkg::RIGHT_EX];
					default:                    ok = 1'b0;
				endcase
			end
			assign hit[m][r] = rif.table_q[r].valid && inb && ok; // see RL5
		end
		assign allow[m] = |hit[m]; // see RL9
		assign tgt[m]   = m_addr[m][bus_protect_pkg::SLAVE_SEL_BIT];
	end

	// Per-master transaction state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_ERR  = 2'b10
	} txn_state_t;

	txn_state_t [NM-1:0] st_r;
	txn_state_t [NM-1:0] st_nxt;
	logic [NM-1:0]       slv_r;
	logic [NM-1:0]       slv_nxt;
	logic [NM-1:0]       done_r;
	logic [NM-1:0]       done_nxt;
	logic [NM-1:0]       err_r;
	logic [NM-1:0]       err_nxt;
	logic [NS-1:0]       owned;

	// A slave is owned by the busy master routed to it
	always_comb begin
		owned = '0;
		for (int m = 0; m < NM; m++) begin
			if (st_r[m] == ST_BUSY) begin
				owned[slv_r[m]] = 1'b1;
			end
		end
	end

	always_comb begin
		logic [NS-1:0] claim;
		claim    = owned;
		st_nxt   = st_r;
		slv_nxt  = slv_r;
		done_nxt = '0;
		err_nxt  = '0;
		m_gnt    = '0;
		for (int m = 0; m < NM; m++) begin
			unique case (st_r[m])
				ST_IDLE: begin
					if (m_req[m] && !allow[m]) begin
						st_nxt[m] = ST_ERR; // see RL4
						m_gnt[m]  = 1'b1;
					end else if (m_req[m] && !claim[tgt[m]]) begin
						// Different slaves proceed in the same cycle; see RL6
						claim[tgt[m]] = 1'b1;
						st_nxt[m]     = ST_BUSY; // see RL3
						slv_nxt[m]    = tgt[m];
						m_gnt[m]      = 1'b1;
					end
				end
				ST_BUSY: begin
					if (s_ack[slv_r[m]]) begin
						st_nxt[m]   = ST_IDLE;
						done_nxt[m] = 1'b1; // see RL3
					end
				end
				ST_ERR: begin
					st_nxt[m]   = ST_IDLE;
					done_nxt[m] = 1'b1;
					err_nxt[m]  = 1'b1; // see RL4
				end
				default: st_nxt[m] = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r   <= '{default: ST_IDLE};
			slv_r  <= '0;
			done_r <= '0;
			err_r  <= '0;
		end else begin
			st_r   <= st_nxt;
			slv_r  <= slv_nxt;
			done_r <= done_nxt;
			err_r  <= err_nxt;
		end
	end

	assign m_done = done_r;
	assign m_err  = err_r;

	// Address and data are captured at grant so the slave sees stable values
	logic [NS-1:0][31:0] sa_r;
	logic [NS-1:0][31:0] sa_nxt;
	logic [NS-1:0][31:0] sd_r;
	logic [NS-1:0][31:0] sd_nxt;
	logic [NS-1:0]       sw_r;
	logic [NS-1:0]       sw_nxt;

	always_comb begin
		sa_nxt = sa_r;
		sd_nxt = sd_r;
		sw_nxt = sw_r;
		for (int m = 0; m < NM; m++) begin
			if (m_gnt[m] && allow[m]) begin
				sa_nxt[tgt[m]] = m_addr[m];
				sd_nxt[tgt[m]] = m_wdata[m];
				sw_nxt[tgt[m]] = (m_kind[m] == bus_protect_pkg::ACC_WRITE);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sa_r <= '0;
			sd_r <= '0;
			sw_r <= '0;
		end else begin
			sa_r <= sa_nxt;
			sd_r <= sd_nxt;
			sw_r <= sw_nxt;
		end
	end

	// Blocked accesses never enter owned, so the slave never sees them
	assign s_req   = owned; // see RL4
	assign s_addr  = sa_r;
	assign s_wdata = sd_r;
	assign s_write = sw_r;

	// Lock bits: sticky until reset, so runaway code cannot unlock them
	logic        plock_r;
	logic        plock_nxt;
	logic        pclk_r;
	logic        pclk_nxt;
	logic [31:0] pcfg_r;
	logic [31:0] pcfg_nxt;

	always_comb begin
		plock_nxt = plock_r | periph_lock_set; // see RL7
		pclk_nxt  = pclk_r | pin_config_lock_wr; // see RL8
		pcfg_nxt  = pcfg_r;
		if (pin_config_wr && !pclk_r) begin
			pcfg_nxt = pin_config_wdata; // see RL8
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			plock_r <= 1'b0;
			pclk_r  <= 1'b0;
			pcfg_r  <= '0;
		end else begin
			plock_r <= plock_nxt;
			pclk_r  <= pclk_nxt;
			pcfg_r  <= pcfg_nxt;
		end
	end

	assign periph_wr_en          = periph_prot_wr && !plock_r; // see RL7
	assign periph_locked         = plock_r;
	assign pin_config_q          = pcfg_r;
	assign pin_config_write_lock = pclk_r;
endmodule

// *** src/bus_protect_pkg.sv ***
package bus_protect_pkg;
	localparam int unsigned NUM_REGIONS = 16;
	localparam int unsigned NUM_MASTERS = 2;
	localparam int unsigned NUM_SLAVES  = 2;
	localparam int unsigned ADDR_W      = 32;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned RIGHT_W     = 3;
	localparam int unsigned DESC_W      = 2 * ADDR_W + 1 + NUM_MASTERS * RIGHT_W;
	localparam int unsigned RIGHT_RD    = 0;
	localparam int unsigned RIGHT_WR    = 1;
	localparam int unsigned RIGHT_EX    = 2;
	localparam int unsigned MASTER_CORE = 0;
	localparam int unsigned MASTER_DMA  = 1;
	localparam logic [ADDR_W-1:0] SLAVE_SEL_MASK = 32'h2000_0000;
	localparam int unsigned SLAVE_SEL_BIT = 29;

	typedef enum logic [1:0] {
		ACC_READ  = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_FETCH = 2'b10
	} acc_kind_t;

	typedef struct packed {
		logic [ADDR_W-1:0]                  start_addr;
		logic [ADDR_W-1:0]                  end_addr;
		logic                               valid;
		logic [NUM_MASTERS-1:0][RIGHT_W-1:0] rights;
	} region_desc_t;
endpackage

// *** src/region_if.sv ***
`timescale 1ns/1ns
interface region_if;
	logic                                         wr_en;
	logic [3:0]                                   wr_idx;
	bus_protect_pkg::region_desc_t                wr_desc;
	bus_protect_pkg::region_desc_t [bus_protect_pkg::NUM_REGIONS-1:0] table_q;

	modport owner (input wr_en, input wr_idx, input wr_desc, output table_q);
	modport user  (output wr_en, output wr_idx, output wr_desc, input table_q);
endinterface

// *** src/region_table.sv ***
`timescale 1ns/1ns
module region_table (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	region_if.owner   rif
);
	bus_protect_pkg::region_desc_t [bus_protect_pkg::NUM_REGIONS-1:0] desc_r;
	bus_protect_pkg::region_desc_t [bus_protect_pkg::NUM_REGIONS-1:0] desc_nxt;

	// Each descriptor is its own program-visible word; see RL1
	always_comb begin
		desc_nxt = desc_r;
		if (rif.wr_en) begin
			desc_nxt[rif.wr_idx] = rif.wr_desc;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			desc_r <= '0;
		end else begin
			desc_r <= desc_nxt;
		end
	end

	assign rif.table_q = desc_r;
endmodule

// *** test/bus_protect_chk.sv ***
`timescale 1ns/1ns
module bus_protect_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [1:0]  m_req,
	input wire logic [1:0]  m_gnt,
	input wire logic [1:0]  m_done,
	input wire logic [1:0]  m_err,
	input wire logic [1:0]  s_req,
	input wire logic [1:0]  s_ack,
	input wire logic        periph_lock_set,
	input wire logic        periph_prot_wr,
	input wire logic        periph_wr_en,
	input wire logic        periph_locked,
	input wire logic [31:0] pin_config_q,
	input wire logic        pin_config_write_lock
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_answer; m_gnt[0] && m_req[0] |-> ##[1:40] m_done[0]; endproperty
	a_answer: assert property (p_answer) else $error("core access never finished");
	property p_err_core; m_err[0] |-> m_done[0]; endproperty
	a_err_core: assert property (p_err_core) else $error("core error without done");
	property p_err_dma; m_err[1] |-> m_done[1]; endproperty
	a_err_dma: assert property (p_err_dma) else $error("dma error without done");
	property p_wr_gate; periph_wr_en == (periph_prot_wr && !periph_locked); endproperty
	a_wr_gate: assert property (p_wr_gate) else $error("peripheral write gate wrong");
	property p_lock_set; periph_lock_set |=> periph_locked ##1 periph_locked; endproperty
	a_lock_set: assert property (p_lock_set) else $error("peripheral lock lost");
	property p_pin_keep;
		pin_config_write_lock |=> $stable(pin_config_q) && pin_config_write_lock;
	endproperty
	a_pin_keep: assert property (p_pin_keep) else $error("locked pin config changed");
	property p_sreq_hold; s_req[1] && !s_ack[1] |=> s_req[1]; endproperty
	a_sreq_hold: assert property (p_sreq_hold) else $error("slave request dropped early");
	property p_sreq_end; s_req[0] && s_ack[0] |=> !s_req[0] && (|m_done); endproperty
	a_sreq_end: assert property (p_sreq_end) else $error("slave ack not completed");
endmodule
bind bus_region_access_protection bus_protect_chk i_bus_protect_chk (.*);

// *** test/slave_model.sv ***
`timescale 1ns/1ns
module slave_model #(parameter int DLY = 0) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic s_req,
	output logic     s_ack
);
	logic [3:0] cnt_r;
	// Count restarts after each pulse, so a request still held afterwards is acked again
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_ack <= 1'b0;
			cnt_r <= 4'h0;
		end else if (s_ack) begin
			s_ack <= 1'b0;
			cnt_r <= 4'h0;
		end else if (s_req) begin
			if (cnt_r == 4'(DLY))
				s_ack <= 1'b1;
			else
				cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

// *** test/bus_region_access_protection_tb.sv ***
`timescale 1ns/1ns
module bus_region_access_protection_tb;
	logic                             clk_sys = 0;
	logic                             rst_n = 0;
	logic                             desc_wr_en = 0;
	logic [3:0]                       desc_wr_idx = 0;
	bus_protect_pkg::region_desc_t    desc_wr_data = '0;
	logic [1:0]                       m_req = 0;
	logic [1:0][31:0]                 m_addr = '0;
	logic [1:0][31:0]                 m_wdata = '0;
	bus_protect_pkg::acc_kind_t [1:0] m_kind = '{bus_protect_pkg::ACC_READ, bus_protect_pkg::ACC_READ};
	logic [1:0]                       m_gnt, m_done, m_err, s_req, s_write, s_ack;
	logic [1:0][31:0]                 s_addr, s_wdata;
	logic                             periph_lock_set = 0, periph_prot_wr = 0;
	logic                             periph_wr_en, periph_locked, pin_config_write_lock;
	logic                             pin_config_lock_wr = 0, pin_config_wr = 0;
	logic [31:0]                      pin_config_wdata = 0, pin_config_q;
	int                               n_fail = 0, samples_checked = 0;
	always #10 clk_sys = ~clk_sys;
	bus_region_access_protection i_bus_region_access_protection (.*);
	// One prompt and one slow slave so both answer paths are exercised
	slave_model #(.DLY(0)) i_slave_model_0 (.clk_sys(clk_sys), .rst_n(rst_n), .s_req(s_req[0]),
		.s_ack(s_ack[0]));
	slave_model #(.DLY(3)) i_slave_model_1 (.clk_sys(clk_sys), .rst_n(rst_n), .s_req(s_req[1]),
		.s_ack(s_ack[1]));
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic desc(int i, logic [31:0] lo, logic [31:0] hi, logic [5:0] rt);
		@(posedge clk_sys);
		desc_wr_en <= 1;
		desc_wr_idx <= i[3:0];
		desc_wr_data <= {lo, hi, 1'b1, rt};
		@(posedge clk_sys);
		desc_wr_en <= 0;
	endtask
	task automatic acc(int m, logic [31:0] a, logic [1:0] k, logic e);
		int n;
		int sl;
		sl = a[bus_protect_pkg::SLAVE_SEL_BIT];
		@(posedge clk_sys);
		m_req[m] <= 1;
		m_addr[m] <= a;
		m_kind[m] <= bus_protect_pkg::acc_kind_t'(k);
		m_wdata[m] <= ~a;
		n = 0;
		do @(negedge clk_sys); while (m_gnt[m] !== 1'b1 && ++n < 50);
		@(posedge clk_sys);
		m_req[m] <= 0;
		// The slave side is looked at in the cycle after the take
		@(negedge clk_sys);
		chk("s_req", !e, s_req[sl]);
		if (!e) begin
			chk("s_addr", a, s_addr[sl]);
			chk("s_write", k == 2'h1, s_write[sl]);
			chk("s_wdata", ~a, s_wdata[sl]);
		end
		n = 0;
		do @(negedge clk_sys); while (m_done[m] !== 1'b1 && ++n < 50);
		chk("done", 1, m_done[m]);
		chk("err", e, m_err[m]);
	endtask
	task t_unmapped;
		acc(0, 32'h0000_1000, 0, 1);
		acc(1, 32'h2000_0000, 1, 1);
	endtask
	task t_rights;
		desc(15, 32'h0000_1000, 32'h0000_1fff, 6'h0b);
		acc(0, 32'h0000_1000, 1, 0);
		acc(1, 32'h0000_1fff, 1, 1);
		acc(1, 32'h0000_1fff, 0, 0);
		acc(0, 32'h0000_2000, 0, 1);
		acc(0, 32'h0000_1000, 2, 1);
		acc(0, 32'h0000_1000, 3, 1);
		desc(3, 32'h0000_1000, 32'h0000_1000, 6'h3f);
		acc(1, 32'h0000_1000, 1, 0);
	endtask
	task t_concurrent;
		desc(0, 32'h2000_0000, 32'h2fff_ffff, 6'h3f);
		fork
			acc(0, 32'h0000_1ffc, 0, 0);
			acc(1, 32'h2000_0010, 2, 0);
			begin
				@(posedge clk_sys);
				@(negedge clk_sys) chk("gnt", 2'h3, m_gnt);
			end
		join
		// Same slave: the core is served first, the DMA waits for its turn
		fork
			acc(0, 32'h0000_1000, 0, 0);
			acc(1, 32'h0000_1000, 0, 0);
			begin
				@(posedge clk_sys);
				@(negedge clk_sys) chk("gnt", 2'h1, m_gnt);
			end
		join
	endtask
	task t_locks;
		@(posedge clk_sys) periph_prot_wr <= 1;
		@(negedge clk_sys) chk("wr_en", 1, periph_wr_en);
		@(posedge clk_sys) periph_lock_set <= 1;
		@(posedge clk_sys) periph_lock_set <= 0;
		@(negedge clk_sys) chk("wr_en", 0, periph_wr_en);
		@(posedge clk_sys) pin_config_wr <= 1;
		pin_config_wdata <= 32'h0000_00a5;
		@(posedge clk_sys) pin_config_wr <= 0;
		pin_config_lock_wr <= 1;
		@(posedge clk_sys) pin_config_lock_wr <= 0;
		pin_config_wr <= 1;
		pin_config_wdata <= 32'h0000_005a;
		@(posedge clk_sys) pin_config_wr <= 0;
		@(negedge clk_sys) chk("pin_q", 32'h0000_00a5, pin_config_q);
		chk("pin_lock", 1, pin_config_write_lock);
	endtask
	task finish_test;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1;
		t_unmapped;
		t_rights;
		t_concurrent;
		t_locks;
		finish_test;
	end
	// Whole run needs under a hundred cycles
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end
endmodule
